//--- core/three_wire_serial_io_pkg.sv
package three_wire_serial_io_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned CNT_W    = 4;
  localparam int unsigned DIV_W    = 3;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MODE_OFS       = 5'h00;
  localparam logic [ADDR_W-1:0] CONTROL_OFS    = 5'h04;
  localparam logic [ADDR_W-1:0] SHIFT_OFS      = 5'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS     = 5'h0C;
  localparam logic [ADDR_W-1:0] PORT_LATCH_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] EXCHANGE_OFS   = 5'h14;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned MODE_CLK_LSB     = 0;
  localparam int unsigned MODE_ORDER_BIT   = 2;
  localparam int unsigned MODE_IRQ_EN_BIT  = 6;
  localparam int unsigned MODE_ENABLE_BIT  = 7;
  localparam int unsigned CTRL_CMD_BIT     = 0;
  localparam int unsigned CTRL_FREE_BIT    = 1;
  localparam int unsigned STATUS_FLAG_BIT  = 0;
  localparam int unsigned STATUS_BUSY_BIT  = 1;
  localparam int unsigned STATUS_SO_BIT    = 2;
  localparam int unsigned STATUS_SCK_BIT   = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] MODE_RESET       = 8'h00;
  localparam logic [DATA_W-1:0] CONTROL_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] SHIFT_RESET      = 8'h00;
  localparam logic              SO_LATCH_RESET   = 1'h1;
  localparam logic              PORT_LATCH_RESET = 1'h1;

  // ------------------------------------------------------------
  // clock sources and counts
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_EXT   = 2'h0,
    CLK_TIMER = 2'h1,
    CLK_FX16  = 2'h2,
    CLK_FX8   = 2'h3
  } clk_sel_t;

  localparam logic [DIV_W-1:0] FX16_HALF_CYCLES = 3'h7;
  localparam logic [DIV_W-1:0] FX8_HALF_CYCLES  = 3'h3;
  localparam logic [CNT_W-1:0] BITS_PER_BYTE    = 4'h8;

endpackage : three_wire_serial_io_pkg

//--- core/three_wire_serial_io.sv
`timescale 1ns/100ps
// What this block does
// - control register clears on reset, single-bit writes
// - command trigger clears output latch, self-clears
// - bus-free trigger sets output latch, self-clears
// - each transfer moves one byte, bitwise
// - shift on falling clock, latch drives output
// - rising clock captures serial input
// - after eighth bit stop, set done flag
// - serial output always follows output latch
// - clock pin port latch gates driven clock
// - mode bits 1:0 select clock source
// - clock masked after byte; access when safe
// - mode bit 2 selects first bit order
// - bit reversal on bus side, fixed shifting
// - data write starts transfer when allowed
// - enabling after data write starts nothing
// - exchange returns received byte, loads, starts
// - later transfers start on each data write when allowed
// - mode register clears on reset, stopped
module three_wire_serial_io (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  output logic             so_o,
  input  wire logic        si_i,
  input  wire logic        timer_flipflop_clock_i
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0] serial_mode_reg;
  logic [7:0] serial_bus_control_reg;
  logic [7:0] shift_reg;
  logic [7:0] exchange_reg;
  logic [7:0] read_byte;
  logic [7:0] write_byte;
  logic [3:0] bit_cnt_reg;
  logic [2:0] div_cnt_reg;
  logic [2:0] div_limit;
  logic       byte_done_irq_flag_reg;
  logic       busy_reg;
  logic       sck_int_reg;
  logic       so_latch_reg;
  logic       clock_pin_port_latch_reg;
  logic       ack_reg;
  logic [31:0] readdata_reg;
  logic       sck_s1_reg;
  logic       sck_s2_reg;
  logic       sck_s3_reg;
  logic       si_s1_reg;
  logic       si_s2_reg;
  logic       tmr_s1_reg;
  logic       tmr_s2_reg;
  logic       tmr_s3_reg;
  logic       port_enable_bit;
  logic       lsb_first;
  logic       internal_clk;
  logic       sck_line;
  logic       tick;
  logic       fall_ev;
  logic       rise_ev;
  logic       last_rise;
  logic       req;
  logic       do_write;
  logic       do_read;
  logic       wr_byte_lane;
  logic       wr_mode;
  logic       wr_control;
  logic       wr_shift;
  logic       wr_status;
  logic       wr_port_latch;
  logic       wr_exchange;
  logic       load_shift;
  logic       start;
  three_wire_serial_io_pkg::clk_sel_t clk_sel;

  function automatic logic [7:0] reverse_byte(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    return r;
  endfunction : reverse_byte

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // only stage 2 and 3 are read; stage 1 may be metastable
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sck_s1_reg <= 1'h1;
      sck_s2_reg <= 1'h1;
      sck_s3_reg <= 1'h1;
      si_s1_reg  <= 1'h0;
      si_s2_reg  <= 1'h0;
      tmr_s1_reg <= 1'h0;
      tmr_s2_reg <= 1'h0;
      tmr_s3_reg <= 1'h0;
    end else if (ce_i) begin
      sck_s1_reg <= sck_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      si_s1_reg  <= si_i;
      si_s2_reg  <= si_s1_reg;
      tmr_s1_reg <= timer_flipflop_clock_i;
      tmr_s2_reg <= tmr_s1_reg;
      tmr_s3_reg <= tmr_s2_reg;
    end
  end

  // ------------------------------------------------------------
  // mode decode and serial clock events
  // ------------------------------------------------------------
  assign port_enable_bit = serial_mode_reg[three_wire_serial_io_pkg::MODE_ENABLE_BIT];
  assign lsb_first       = serial_mode_reg[three_wire_serial_io_pkg::MODE_ORDER_BIT];
  assign clk_sel         = three_wire_serial_io_pkg::clk_sel_t'(
                             serial_mode_reg[three_wire_serial_io_pkg::MODE_CLK_LSB +: 2]);
  assign internal_clk    = (clk_sel != three_wire_serial_io_pkg::CLK_EXT);
  assign sck_line        = internal_clk ? sck_int_reg : sck_s2_reg;

  always_comb begin
    div_limit = three_wire_serial_io_pkg::FX16_HALF_CYCLES;
    tick      = 1'h0;
    case (clk_sel)
      three_wire_serial_io_pkg::CLK_TIMER: begin
        // one half period per timer rising edge
        tick = tmr_s2_reg & ~tmr_s3_reg;
      end
      three_wire_serial_io_pkg::CLK_FX16: begin
        div_limit = three_wire_serial_io_pkg::FX16_HALF_CYCLES;
        tick      = (div_cnt_reg == div_limit);
      end
      three_wire_serial_io_pkg::CLK_FX8: begin
        div_limit = three_wire_serial_io_pkg::FX8_HALF_CYCLES;
        tick      = (div_cnt_reg == div_limit);
      end
      default: begin
        tick = 1'h0;
      end
    endcase
  end

  always_comb begin
    if (internal_clk) begin
      fall_ev = busy_reg & tick & sck_int_reg;
      rise_ev = busy_reg & tick & ~sck_int_reg;
    end else begin
      fall_ev = busy_reg & ~sck_s2_reg & sck_s3_reg;
      rise_ev = busy_reg & sck_s2_reg & ~sck_s3_reg;
    end
  end

  assign last_rise = rise_ev & (bit_cnt_reg == three_wire_serial_io_pkg::BITS_PER_BYTE - 4'h1);

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // one wait state: the answer is registered so decode stays off the bus path
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign do_write          = avs_write_i & ack_reg;
  assign do_read           = avs_read_i & ~ack_reg;
  assign wr_byte_lane      = do_write & avs_byteenable_i[0];
  assign write_byte        = avs_writedata_i[7:0];
  assign wr_mode           = wr_byte_lane & (avs_address_i == three_wire_serial_io_pkg::MODE_OFS);
  assign wr_control        = wr_byte_lane & (avs_address_i == three_wire_serial_io_pkg::CONTROL_OFS);
  assign wr_shift          = wr_byte_lane & (avs_address_i == three_wire_serial_io_pkg::SHIFT_OFS);
  assign wr_status         = wr_byte_lane & (avs_address_i == three_wire_serial_io_pkg::STATUS_OFS);
  assign wr_port_latch     = wr_byte_lane & (avs_address_i == three_wire_serial_io_pkg::PORT_LATCH_OFS);
  assign wr_exchange       = wr_byte_lane & (avs_address_i == three_wire_serial_io_pkg::EXCHANGE_OFS);
  assign load_shift        = wr_shift | wr_exchange;
  // enabling alone never starts; only the data write does
  assign start             = load_shift & port_enable_bit & (~busy_reg | sck_line);
  assign read_byte         = lsb_first ? reverse_byte(shift_reg) : shift_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'h0;
    end else if (ce_i) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      readdata_reg <= 32'h0000_0000;
    end else if (ce_i && do_read) begin
      case (avs_address_i)
        three_wire_serial_io_pkg::MODE_OFS:       readdata_reg <= {24'h000000, serial_mode_reg};
        three_wire_serial_io_pkg::SHIFT_OFS:      readdata_reg <= {24'h000000, read_byte};
        three_wire_serial_io_pkg::STATUS_OFS:     readdata_reg <= {28'h0000000, sck_line, so_latch_reg,
                                                                   busy_reg, byte_done_irq_flag_reg};
        three_wire_serial_io_pkg::PORT_LATCH_OFS: readdata_reg <= {31'h00000000, clock_pin_port_latch_reg};
        three_wire_serial_io_pkg::EXCHANGE_OFS:   readdata_reg <= {24'h000000, exchange_reg};
        // control triggers are write-only and read as zero
        default:                                  readdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_o = readdata_reg;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      serial_mode_reg <= three_wire_serial_io_pkg::MODE_RESET;
    end else if (ce_i && wr_mode) begin
      serial_mode_reg <= write_byte;
    end
  end

  // trigger bits live one cycle, then drop back to zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      serial_bus_control_reg <= three_wire_serial_io_pkg::CONTROL_RESET;
    end else if (ce_i) begin
      if (wr_control) begin
        serial_bus_control_reg <= write_byte;
      end else begin
        serial_bus_control_reg <= three_wire_serial_io_pkg::CONTROL_RESET;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      clock_pin_port_latch_reg <= three_wire_serial_io_pkg::PORT_LATCH_RESET;
    end else if (ce_i && wr_port_latch) begin
      clock_pin_port_latch_reg <= write_byte[0];
    end
  end

  // set wins over a same-cycle write-one-to-clear
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      byte_done_irq_flag_reg <= 1'h0;
    end else if (ce_i) begin
      if (last_rise) begin
        byte_done_irq_flag_reg <= 1'h1;
      end else if (wr_status && write_byte[three_wire_serial_io_pkg::STATUS_FLAG_BIT]) begin
        byte_done_irq_flag_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      exchange_reg <= three_wire_serial_io_pkg::SHIFT_RESET;
    end else if (ce_i && wr_exchange) begin
      exchange_reg <= read_byte;
    end
  end

  // ------------------------------------------------------------
  // transfer engine
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      busy_reg    <= 1'h0;
      bit_cnt_reg <= 4'h0;
    end else if (ce_i) begin
      if (!port_enable_bit) begin
        busy_reg    <= 1'h0;
        bit_cnt_reg <= 4'h0;
      end else if (start) begin
        busy_reg    <= 1'h1;
        bit_cnt_reg <= 4'h0;
      end else if (last_rise) begin
        busy_reg    <= 1'h0;
        bit_cnt_reg <= 4'h0;
      end else if (rise_ev) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= 3'h0;
    end else if (ce_i) begin
      if (start || !busy_reg || tick) begin
        div_cnt_reg <= 3'h0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 3'h1;
      end
    end
  end

  // idles high; masked high once the byte is done
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sck_int_reg <= 1'h1;
    end else if (ce_i) begin
      if (!busy_reg || start) begin
        sck_int_reg <= 1'h1;
      end else if (internal_clk && tick) begin
        sck_int_reg <= ~sck_int_reg;
      end
    end
  end

  // physical shift is always toward bit 7; order is swapped at the bus
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_reg <= three_wire_serial_io_pkg::SHIFT_RESET;
    end else if (ce_i) begin
      if (load_shift) begin
        shift_reg <= lsb_first ? reverse_byte(write_byte) : write_byte;
      end else if (fall_ev) begin
        shift_reg <= {shift_reg[6:0], shift_reg[0]};
      end else if (rise_ev) begin
        shift_reg[0] <= si_s2_reg;
      end
    end
  end

  // triggers are honoured even mid-byte; software keeps them out of transfers
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      so_latch_reg <= three_wire_serial_io_pkg::SO_LATCH_RESET;
    end else if (ce_i) begin
      if (fall_ev) begin
        so_latch_reg <= shift_reg[7];
      end else if (serial_bus_control_reg[three_wire_serial_io_pkg::CTRL_CMD_BIT] &&
                   !serial_bus_control_reg[three_wire_serial_io_pkg::CTRL_FREE_BIT]) begin
        so_latch_reg <= 1'h0;
      end else if (serial_bus_control_reg[three_wire_serial_io_pkg::CTRL_FREE_BIT] &&
                   !serial_bus_control_reg[three_wire_serial_io_pkg::CTRL_CMD_BIT]) begin
        so_latch_reg <= 1'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  assign so_o     = so_latch_reg;
  assign sck_o    = sck_int_reg & clock_pin_port_latch_reg;
  assign sck_oe_o = internal_clk;

endmodule : three_wire_serial_io

//--- test/three_wire_serial_io_chk.sv
`timescale 1ns/100ps
module three_wire_serial_io_chk (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        sck_o,
  input wire logic        sck_oe_o,
  input wire logic        so_o
);
  // ------------------------------------------------------------
  // mirrors of software writes
  // ------------------------------------------------------------
  logic       wr_ok, wr_mode, wr_ctrl, data_wr, int_fall;
  logic [1:0] clk_sel_reg;
  logic       pin_latch_reg;
  logic [3:0] fall_cnt_reg;
  assign wr_ok    = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign wr_mode  = wr_ok && avs_address_i == three_wire_serial_io_pkg::MODE_OFS;
  assign wr_ctrl  = wr_ok && avs_address_i == three_wire_serial_io_pkg::CONTROL_OFS;
  assign data_wr  = wr_ok && (avs_address_i == three_wire_serial_io_pkg::SHIFT_OFS ||
                              avs_address_i == three_wire_serial_io_pkg::EXCHANGE_OFS);
  assign int_fall = !sck_o && sck_oe_o && pin_latch_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      clk_sel_reg   <= 2'h0;
      pin_latch_reg <= 1'h1;
    end else if (wr_mode) begin
      clk_sel_reg <= avs_writedata_i[1:0];
    end else if (wr_ok && avs_address_i == three_wire_serial_io_pkg::PORT_LATCH_OFS) begin
      pin_latch_reg <= avs_writedata_i[0];
    end
  end
  // latch-forced lows are not clock periods, so they stay out of the count
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || data_wr) begin
      fall_cnt_reg <= 4'h0;
    end else if ($fell(sck_o) && int_fall) begin
      fall_cnt_reg <= fall_cnt_reg + 4'h1;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_low_fx8;
    !sck_o [*4] ##1 sck_o;
  endsequence
  sequence s_low_fx16;
    !sck_o [*8] ##1 sck_o;
  endsequence
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");
  a_cmd_clears: assert property (wr_ctrl && avs_writedata_i[1:0] == 2'h1 |-> ##[1:2] so_o == 1'b0)
    else $error("command trigger left output high");
  a_free_sets: assert property (wr_ctrl && avs_writedata_i[1:0] == 2'h2 |-> ##[1:2] so_o == 1'b1)
    else $error("bus-free trigger left output low");
  a_oe_follows: assert property (wr_mode |-> ##[1:2] sck_oe_o == (clk_sel_reg != 2'h0))
    else $error("clock pin direction wrong");
  a_fx8_low: assert property ($fell(sck_o) && int_fall && clk_sel_reg == 2'h3 |-> s_low_fx8)
    else $error("fx8 half period wrong");
  a_fx16_low: assert property ($fell(sck_o) && int_fall && clk_sel_reg == 2'h2 |-> s_low_fx16)
    else $error("fx16 half period wrong");
  a_eight_falls: assert property ($fell(sck_o) && int_fall |-> fall_cnt_reg < 4'h8)
    else $error("more than eight clock periods");
  a_idle_high: assert property ($rose(sck_o) && sck_oe_o && fall_cnt_reg == 4'h8 |=> sck_o [*4])
    else $error("clock not masked high after byte");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 5'h14 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : three_wire_serial_io_chk

bind three_wire_serial_io three_wire_serial_io_chk u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .sck_o(sck_o),
  .sck_oe_o(sck_oe_o), .so_o(so_o)
);

//--- test/serial_peer_model.sv
`timescale 1ns/100ps
module serial_peer_model (
  input  wire logic       sck_line_i,
  input  wire logic       so_i,
  output logic            sck_ext_o,
  output logic            si_o,
  output logic [7:0]      rx_byte_o
);
  logic [7:0] tx_reg;
  int         bit_cnt;
  initial begin
    sck_ext_o = 1'b1;
    si_o      = 1'b1;
    tx_reg    = 8'h00;
    rx_byte_o = 8'h00;
    bit_cnt   = 0;
  end
  task automatic load(input logic [7:0] b);
    tx_reg  = b;
    bit_cnt = 0;
  endtask : load
  // clock stands high between frames, so a start always finds it high
  task automatic run_ext();
    #3;
    repeat (8) begin
      sck_ext_o = 1'b0;
      #80;
      sck_ext_o = 1'b1;
      #80;
    end
  endtask : run_ext
  // drive on the fall: the bit settles a half period before capture
  always @(negedge sck_line_i) begin
    si_o   = tx_reg[7];
    tx_reg = {tx_reg[6:0], 1'b0};
  end
  always @(posedge sck_line_i) begin
    rx_byte_o = {rx_byte_o[6:0], so_i};
    bit_cnt++;
    // hold time over: show the inverse, not a stale level
    if (bit_cnt == 8) begin
      #60;
      si_o = ~si_o;
    end
  end
endmodule : serial_peer_model

//--- test/tb_three_wire_serial_io.sv
`timescale 1ns/100ps
module tb_three_wire_serial_io;
  localparam logic [4:0] A_MODE = three_wire_serial_io_pkg::MODE_OFS;
  localparam logic [4:0] A_CTRL = three_wire_serial_io_pkg::CONTROL_OFS;
  localparam logic [4:0] A_SHIFT = three_wire_serial_io_pkg::SHIFT_OFS;
  localparam logic [4:0] A_STAT = three_wire_serial_io_pkg::STATUS_OFS;
  logic        clock_i, rst_n_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        sck_o, sck_oe_o, so_o, si_i, sck_ext, sck_line, timer_ff;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i, be_v;
  logic [7:0]  peer_rx, q;
  logic [2:0]  tdiv_reg;
  int          err_total, cmp_count;
  three_wire_serial_io u_three_wire_serial_io (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .sck_i(sck_ext), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .so_o(so_o), .si_i(si_i), .timer_flipflop_clock_i(timer_ff)
  );
  assign sck_line = sck_oe_o ? sck_o : sck_ext;
  serial_peer_model u_serial_peer_model (
    .sck_line_i(sck_line), .so_i(so_o), .sck_ext_o(sck_ext), .si_o(si_i), .rx_byte_o(peer_rx)
  );
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus_op(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    avs_address_i    <= a;
    avs_write_i      <= w;
    avs_read_i       <= !w;
    avs_writedata_i  <= {24'h0, d};
    avs_byteenable_i <= be_v;
    // answer and read data taken at the rising edge itself; only the watchdog ends a hang
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0);
    check(8'(n), 8'h02);
    r = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clock_i);
  endtask : bus_op
  task automatic chk_so(input logic e);
    logic [7:0] s;
    bus_op(1'b0, A_STAT, 8'h00, s);
    check({6'h0, s[2], so_o}, {6'h0, e, e});
  endtask : chk_so
  task automatic xfer(input logic [7:0] m, input logic [4:0] a, input logic [7:0] d, input logic [7:0] p,
                      input logic [7:0] e_peer, input logic [7:0] e_rd);
    logic [7:0] r;
    int         n;
    n = 0;
    u_serial_peer_model.load(p);
    bus_op(1'b1, A_MODE, m, r);
    bus_op(1'b1, a, d, r);
    if (m[1:0] == 2'h0) u_serial_peer_model.run_ext();
    do begin
      bus_op(1'b0, A_STAT, 8'h00, r);
      n++;
    end while (r[1] !== 1'b0 && n < 500);
    check({6'h0, r[1:0]}, 8'h01);
    check(peer_rx, e_peer);
    check({7'h0, sck_o}, 8'h01);
    bus_op(1'b0, a, 8'h00, r);
    check(r, e_rd);
    bus_op(1'b1, A_STAT, 8'h01, r);
  endtask : xfer
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // clock, timer source, watchdog
  // ------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    tdiv_reg <= (tdiv_reg == 3'h5) ? 3'h0 : tdiv_reg + 3'h1;
    if (tdiv_reg == 3'h5) timer_ff <= ~timer_ff;
  end
  // far beyond the few microseconds the sequence needs
  initial begin
    #400000;
    err_total++;
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    give_verdict();
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = '0;
    {ce_i, timer_ff, tdiv_reg, be_v, err_total, cmp_count} = {1'b1, 1'b0, 3'h0, 4'hF, 32'h0, 32'h0};
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    bus_op(1'b0, A_MODE, 8'h00, q);
    check(q, three_wire_serial_io_pkg::MODE_RESET);
    bus_op(1'b0, A_CTRL, 8'h00, q);
    check(q, three_wire_serial_io_pkg::CONTROL_RESET);
    check({7'h0, sck_oe_o}, 8'h00);
    be_v = 4'h0;
    bus_op(1'b1, A_CTRL, 8'h01, q);
    be_v = 4'hF;
    chk_so(1'b1);
    for (int i = 0; i < 5; i++) begin
      bus_op(1'b1, A_CTRL, 8'h01 + {6'h0, i == 3, i == 1 || i == 4}, q);
      chk_so(i == 1 || i == 4);
    end
    bus_op(1'b0, A_CTRL, 8'h00, q);
    check(q, 8'h00);
    xfer(8'h83, A_SHIFT, 8'h1E, 8'hC5, 8'h1E, 8'hC5);
    xfer(8'h86, A_SHIFT, 8'h1E, 8'hC5, 8'h78, 8'hA3);
    xfer(8'h81, A_SHIFT, 8'h5A, 8'h96, 8'h5A, 8'h96);
    bus_op(1'b1, A_MODE, 8'h00, q);
    bus_op(1'b1, A_SHIFT, 8'h33, q);
    bus_op(1'b1, A_MODE, 8'h80, q);
    bus_op(1'b0, A_STAT, 8'h00, q);
    check({7'h0, q[1]}, 8'h00);
    xfer(8'h80, A_SHIFT, 8'hF0, 8'h0F, 8'hF0, 8'h0F);
    xfer(8'h83, three_wire_serial_io_pkg::EXCHANGE_OFS, 8'h69, 8'h24, 8'h69, 8'h0F);
    bus_op(1'b0, A_SHIFT, 8'h00, q);
    check(q, 8'h24);
    // abort mid-byte on the slow timer clock
    bus_op(1'b1, A_MODE, 8'hC1, q);
    bus_op(1'b1, A_SHIFT, 8'hA5, q);
    bus_op(1'b0, A_STAT, 8'h00, q);
    check({7'h0, q[1]}, 8'h01);
    bus_op(1'b1, A_MODE, 8'h81, q);
    bus_op(1'b1, A_MODE, 8'h01, q);
    bus_op(1'b1, A_STAT, 8'h01, q);
    bus_op(1'b0, A_STAT, 8'h00, q);
    check({6'h0, q[1:0]}, 8'h00);
    bus_op(1'b1, three_wire_serial_io_pkg::PORT_LATCH_OFS, 8'h00, q);
    bus_op(1'b0, A_STAT, 8'h00, q);
    // internal clock stands high; only the pin is pulled low by the latch
    check({6'h0, q[3], sck_o}, 8'h02);
    bus_op(1'b1, three_wire_serial_io_pkg::PORT_LATCH_OFS, 8'h01, q);
    bus_op(1'b0, 5'h18, 8'h00, q);
    check(q, 8'h00);
    give_verdict();
  end
endmodule : tb_three_wire_serial_io
